/* mcr_top.sv */
// mmu control register set top
// assumes single-cycle register strobes from the cpu core
`timescale 1ns/1ps
module mcr_top (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [31:0] i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	output logic      [31:0] o_reg_rdata,
	input  wire logic        i_fault,
	input  wire logic [31:0] i_fault_addr,
	input  wire logic        i_instruction_translation_buffer_use,
	input  wire logic [1:0]  i_instruction_translation_buffer_use_idx,
	output logic      [1:0]  o_instruction_translation_buffer_victim,
	input  wire logic        i_unified_translation_buffer_access,
	input  wire logic        i_load_entry,
	output logic      [5:0]  o_replace_index,
	output logic             o_invalidate_all,
	output logic             o_translation_enable,
	output logic             o_single_space_mode,
	output logic             o_store_queue_protect,
	input  wire logic        i_sq_access,
	input  wire logic        i_user_mode,
	output logic             o_sq_addr_error,
	output logic      [2:0]  o_card_space_attribute,
	output logic             o_card_timing_select,
	output logic      [31:0] o_page_entry_high,
	output logic      [31:0] o_page_entry_low,
	output logic      [31:0] o_page_entry_assist
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [5:0] lru_upd(input logic [5:0] l, input logic [1:0] e);
		logic [5:0] n;
		n = l;
		case (e)
			2'h0: begin
				n[5] = 1'b0; n[4] = 1'b0; n[3] = 1'b0;
			end
			2'h1: begin
				n[5] = 1'b1; n[2] = 1'b0; n[1] = 1'b0;
			end
			2'h2: begin
				n[4] = 1'b1; n[2] = 1'b1; n[0] = 1'b0;
			end
			default: begin
				n[3] = 1'b1; n[1] = 1'b1; n[0] = 1'b1;
			end
		endcase
		lru_upd = n;
	endfunction

	mcr_pkg::mcr_state_t s_reg;
	mcr_pkg::mcr_state_t s_next;
	logic rst_n;
	logic [5:0] urc_inc;
	logic [31:0] ctl_rd;

	assign rst_n = s_reg.rst_sync[1];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
		s_next.inval = 1'b0;
		ctl_rd = mcr_pkg::MCR_ZERO32;
		ctl_rd[mcr_pkg::MCR_LRU_LSB +: 6] = s_reg.lru;
		ctl_rd[mcr_pkg::MCR_URB_LSB +: 6] = s_reg.replace_boundary;
		ctl_rd[mcr_pkg::MCR_URC_LSB +: 6] = s_reg.replace_counter;
		ctl_rd[mcr_pkg::MCR_STORE_QUEUE_PROTECT_BIT] = s_reg.store_queue_protect;
		ctl_rd[mcr_pkg::MCR_SV_BIT] = s_reg.sv;
		ctl_rd[mcr_pkg::MCR_AT_BIT] = s_reg.at;
		// counter step with boundary handling
		urc_inc = s_reg.replace_counter + 6'h01;
		if (s_reg.replace_boundary != mcr_pkg::MCR_ZERO6 && urc_inc == s_reg.replace_boundary) begin
			urc_inc = mcr_pkg::MCR_ZERO6;
		end
		if (i_unified_translation_buffer_access && !i_load_entry) begin
			s_next.replace_counter = urc_inc;
		end
		if (i_instruction_translation_buffer_use) begin
			s_next.lru = lru_upd(s_reg.lru, i_instruction_translation_buffer_use_idx);
		end
		if (i_fault) begin
			s_next.fa = i_fault_addr;
			s_next.peh[31:mcr_pkg::MCR_VPN_LSB] = i_fault_addr[31:mcr_pkg::MCR_VPN_LSB];
		end
		if (i_reg_wr) begin
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_PEH)) begin
				s_next.peh = i_reg_wdata;
			end
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_PEL)) begin
				s_next.pel = i_reg_wdata;
			end
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_TB)) begin
				s_next.tb = i_reg_wdata;
			end
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_FA)) begin
				s_next.fa = i_reg_wdata;
			end
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_PEA)) begin
				s_next.pea = i_reg_wdata;
			end
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_CTL)) begin
				s_next.lru = i_reg_wdata[mcr_pkg::MCR_LRU_LSB +: 6];
				s_next.replace_boundary = i_reg_wdata[mcr_pkg::MCR_URB_LSB +: 6];
				s_next.replace_counter = i_reg_wdata[mcr_pkg::MCR_URC_LSB +: 6];
				s_next.store_queue_protect = i_reg_wdata[mcr_pkg::MCR_STORE_QUEUE_PROTECT_BIT];
				s_next.sv = i_reg_wdata[mcr_pkg::MCR_SV_BIT];
				s_next.at = i_reg_wdata[mcr_pkg::MCR_AT_BIT];
				s_next.inval = i_reg_wdata[mcr_pkg::MCR_TI_BIT];
			end
		end
		s_next.rdata = mcr_pkg::MCR_ZERO32;
		if (i_reg_rd) begin
			if (hit(i_reg_addr, mcr_pkg::MCR_OFF_PEH)) begin
				s_next.rdata = s_reg.peh;
			end else if (hit(i_reg_addr, mcr_pkg::MCR_OFF_PEL)) begin
				s_next.rdata = s_reg.pel;
			end else if (hit(i_reg_addr, mcr_pkg::MCR_OFF_TB)) begin
				s_next.rdata = s_reg.tb;
			end else if (hit(i_reg_addr, mcr_pkg::MCR_OFF_FA)) begin
				s_next.rdata = s_reg.fa;
			end else if (hit(i_reg_addr, mcr_pkg::MCR_OFF_CTL)) begin
				s_next.rdata = ctl_rd;
			end else if (hit(i_reg_addr, mcr_pkg::MCR_OFF_PEA)) begin
				s_next.rdata = s_reg.pea;
			end
		end
		// state stays clear until the release copy has settled
		if (!rst_n) begin
			s_next = '0;
			s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		if (s_reg.lru[5] && s_reg.lru[4] && s_reg.lru[3]) begin
			o_instruction_translation_buffer_victim = 2'h0;
		end else if (!s_reg.lru[5] && s_reg.lru[2] && s_reg.lru[1]) begin
			o_instruction_translation_buffer_victim = 2'h1;
		end else if (!s_reg.lru[4] && !s_reg.lru[2] && s_reg.lru[0]) begin
			o_instruction_translation_buffer_victim = 2'h2;
		end else begin
			o_instruction_translation_buffer_victim = 2'h3;
		end
	end

	assign o_reg_rdata           = s_reg.rdata;
	assign o_replace_index       = s_reg.replace_counter;
	assign o_invalidate_all      = s_reg.inval;
	assign o_translation_enable  = s_reg.at;
	assign o_single_space_mode   = s_reg.sv;
	assign o_store_queue_protect = s_reg.store_queue_protect;
	assign o_sq_addr_error       = i_sq_access && i_user_mode && s_reg.store_queue_protect;
	assign o_card_space_attribute = s_reg.pea[mcr_pkg::MCR_SA_LSB +: 3];
	assign o_card_timing_select  = s_reg.pea[mcr_pkg::MCR_TC_BIT];
	assign o_page_entry_high     = s_reg.peh;
	assign o_page_entry_low      = s_reg.pel;
	assign o_page_entry_assist   = s_reg.pea;
endmodule // mcr_top

/* mcr_pkg.sv */
// mmu control register set: shared constants and types
// assumes a 32-bit privileged register port on the cpu core side
// Notes on behaviour
// - fault loads page number from upper 22 bits
// - space identifier changes only by software write
// - low entry holds page data, software only
// - card area uses assist bits when untranslated
// - translation base is plain software storage
// - fault captures full address; software may write
// - instruction buffer use updates lru bits
// - miss victim chosen from lru bits
// - lru cleared at reset; software avoids prohibited
// - replacement counter picks load-entry victim
// - counter steps on buffer access, not load
// - nonzero boundary wraps counter to zero
// - counter above boundary runs to 3f first
// - store-queue protect blocks user access when set
// - mode bit selects single or multiple space
// - invalidate write clears valid bits; reads zero
// - enable bit gates translation and its exceptions
package mcr_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [31:0] MCR_OFF_PEH  = 32'hff00_0000;
	localparam logic [31:0] MCR_OFF_PEL  = 32'hff00_0004;
	localparam logic [31:0] MCR_OFF_TB   = 32'hff00_0008;
	localparam logic [31:0] MCR_OFF_FA   = 32'hff00_000c;
	localparam logic [31:0] MCR_OFF_CTL  = 32'hff00_0010;
	localparam logic [31:0] MCR_OFF_PEA  = 32'hff00_0034;
	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int MCR_VPN_LSB  = 10;
	localparam int MCR_ADDRESS_SPACE_IDENTIFIER_W   = 8;
	localparam int MCR_LRU_LSB  = 26;
	localparam int MCR_URB_LSB  = 18;
	localparam int MCR_URC_LSB  = 10;
	localparam int MCR_STORE_QUEUE_PROTECT_BIT = 9;
	localparam int MCR_SV_BIT   = 8;
	localparam int MCR_TI_BIT   = 2;
	localparam int MCR_AT_BIT   = 0;
	localparam int MCR_SA_LSB   = 0;
	localparam int MCR_TC_BIT   = 3;
	localparam logic [5:0]  MCR_CNT_MAX = 6'h3f;
	localparam logic [5:0]  MCR_ZERO6   = 6'h00;
	localparam logic [31:0] MCR_ZERO32  = 32'h0000_0000;
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  rst_sync;
		logic [31:0] peh;
		logic [31:0] pel;
		logic [31:0] tb;
		logic [31:0] fa;
		logic [31:0] pea;
		logic [5:0]  lru;
		logic [5:0]  replace_boundary;
		logic [5:0]  replace_counter;
		logic        store_queue_protect;
		logic        sv;
		logic        at;
		logic        inval;
		logic [31:0] rdata;
	} mcr_state_t;
endpackage

/* mcr_props.sv */
// checker of the mmu control register set
// assumes it is bound to mcr_top and sees its ports
`timescale 1ns/1ps
module mcr_props (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        i_reg_wr,
	input wire logic [31:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic        i_fault,
	input wire logic [31:0] i_fault_addr,
	input wire logic        i_unified_translation_buffer_access,
	input wire logic        i_load_entry,
	input wire logic [5:0]  o_replace_index,
	input wire logic        o_invalidate_all,
	input wire logic        o_translation_enable,
	input wire logic        o_store_queue_protect,
	input wire logic [31:0] o_page_entry_high,
	input wire logic [31:0] o_page_entry_low
);
	// ---
	// properties
	// ---
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_ctl_wr;
		i_reg_wr && i_reg_addr == mcr_pkg::MCR_OFF_CTL;
	endsequence
	sequence s_one_pulse;
		o_invalidate_all ##1 !o_invalidate_all;
	endsequence
	property p_inval;
		s_ctl_wr ##0 i_reg_wdata[2] ##1 !i_reg_wr |-> s_one_pulse;
	endproperty
	property p_at;
		s_ctl_wr |=> o_translation_enable == $past(i_reg_wdata[0]);
	endproperty
	property p_sqp;
		s_ctl_wr |=> o_store_queue_protect == $past(i_reg_wdata[9]);
	endproperty
	property p_fault;
		i_fault && !i_reg_wr |=>
			o_page_entry_high[31:10] == $past(i_fault_addr[31:10]) &&
			$stable(o_page_entry_high[7:0]);
	endproperty
	property p_address_space_identifier;
		!i_reg_wr |=> $stable(o_page_entry_high[7:0]);
	endproperty
	property p_low;
		!i_reg_wr |=> $stable(o_page_entry_low);
	endproperty
	property p_wrap;
		i_unified_translation_buffer_access && !i_load_entry && !i_reg_wr && o_replace_index == 6'h3f
			|=> o_replace_index == 6'h00;
	endproperty
	property p_load;
		i_load_entry && !i_reg_wr |=> $stable(o_replace_index);
	endproperty
	a_inval: assert property (p_inval) else $error("invalidate pulse wrong");
	a_at: assert property (p_at) else $error("enable bit wrong");
	a_sqp: assert property (p_sqp) else $error("queue protect wrong");
	a_fault: assert property (p_fault) else $error("fault capture wrong");
	a_address_space_identifier: assert property (p_address_space_identifier) else $error("space identifier moved");
	a_low: assert property (p_low) else $error("low entry moved");
	a_wrap: assert property (p_wrap) else $error("counter wrap wrong");
	a_load: assert property (p_load) else $error("load stepped counter");
endmodule // mcr_props

bind mcr_top mcr_props u_props (.i_clk, .i_arst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
	.i_fault, .i_fault_addr, .i_unified_translation_buffer_access, .i_load_entry, .o_replace_index,
	.o_invalidate_all, .o_translation_enable, .o_store_queue_protect,
	.o_page_entry_high, .o_page_entry_low);

/* mcr_cpu.sv */
// cpu core model issuing privileged register accesses
// assumes strobes are sampled on the rising edge
`timescale 1ns/1ps
module mcr_cpu (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	output logic             o_wr = 0,
	output logic             o_rd = 0,
	output logic      [31:0] o_addr = 0,
	output logic      [31:0] o_wdata = 0
);
	// ---
	// accesses run from kernel unmapped code
	// ---
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clk) begin
			o_wr <= 1;
			o_addr <= a;
			o_wdata <= d;
		end
		@(posedge i_clk) begin
			o_wr <= 0;
			o_wdata <= ~d;
		end
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge i_clk) begin
			o_rd <= 1;
			o_addr <= a;
		end
		@(posedge i_clk) o_rd <= 0;
		#1 d = i_rdata;
	endtask
endmodule // mcr_cpu

/* tb_mcr_top.sv */
// self-checking bench of the mmu control register set
// assumes mcr_props is bound and mcr_cpu drives registers
`timescale 1ns/1ps
module tb_mcr_top;
	// ---
	// bench
	// ---
	logic        i_clk = 0, i_arst_n = 0, i_fault = 0, i_instruction_translation_buffer_use = 0;
	logic        i_unified_translation_buffer_access = 0, i_load_entry = 0, i_sq_access = 0, i_user_mode = 0;
	logic        wr, rd, o_invalidate_all, o_translation_enable, o_single_space_mode;
	logic        o_store_queue_protect, o_sq_addr_error, o_card_timing_select;
	logic [1:0]  i_instruction_translation_buffer_use_idx = 0, o_instruction_translation_buffer_victim;
	logic [2:0]  o_card_space_attribute;
	logic [5:0]  o_replace_index;
	logic [15:0] sd = 16'd5108;
	logic [31:0] i_fault_addr = 0, addr, wdata, o_reg_rdata, r, d, mr [5];
	logic [31:0] o_page_entry_high, o_page_entry_low, o_page_entry_assist;
	logic [31:0] off [5] = '{32'hff00_0000, 32'hff00_0004, 32'hff00_0008,
		32'hff00_000c, 32'hff00_0034};
	int          bad_count = 0, num_checks = 0, cyc = 0, j, k;
	int          lru = 0, replace_boundary = 0, replace_counter = 0, sqp = 0, sv = 0, at = 0;
	mcr_top dut (.i_clk, .i_arst_n, .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_rdata, .i_fault, .i_fault_addr, .i_instruction_translation_buffer_use,
		.i_instruction_translation_buffer_use_idx, .o_instruction_translation_buffer_victim, .i_unified_translation_buffer_access, .i_load_entry, .o_replace_index,
		.o_invalidate_all, .o_translation_enable, .o_single_space_mode,
		.o_store_queue_protect, .i_sq_access, .i_user_mode, .o_sq_addr_error,
		.o_card_space_attribute, .o_card_timing_select, .o_page_entry_high,
		.o_page_entry_low, .o_page_entry_assist);
	mcr_cpu cpu (.i_clk, .i_rdata(o_reg_rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_wdata(wdata));
	initial forever #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			report_and_stop;
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wctl(input logic [31:0] v);
		cpu.wr(mcr_pkg::MCR_OFF_CTL, v);
		lru = v[31:26];
		replace_boundary = v[23:18];
		replace_counter = v[15:10];
		sqp = v[9];
		sv = v[8];
		at = v[0];
		#1 chk(o_invalidate_all, v[2]);
		cpu.rd(mcr_pkg::MCR_OFF_CTL, r);
		chk(r, 32'(lru << 26 | replace_boundary << 18 | replace_counter << 10 | sqp << 9 | sv << 8 | at));
		chk(o_translation_enable, at);
		chk(o_invalidate_all, 0);
		repeat (8) @(posedge i_clk); // spacing
	endtask
	task ev(input int w, input logic [31:0] a);
		@(posedge i_clk) begin
			i_fault <= w == 0;
			i_fault_addr <= a;
			i_instruction_translation_buffer_use <= w == 1;
			i_instruction_translation_buffer_use_idx <= a[1:0];
			i_unified_translation_buffer_access <= w == 2 || w == 3;
			i_load_entry <= w == 3;
		end
		@(posedge i_clk) {i_fault, i_instruction_translation_buffer_use, i_unified_translation_buffer_access, i_load_entry} <= 0;
		#1;
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1;
		repeat (3) @(posedge i_clk);
		cpu.rd(mcr_pkg::MCR_OFF_CTL, r);
		chk(r, 0);
		for (j = 0; j < 5; j++) begin
			sd = lfsr(sd);
			mr[j] = {sd, ~sd};
			cpu.wr(off[j], mr[j]);
		end
		for (j = 0; j < 6; j++) begin
			cpu.rd(j < 5 ? off[j] : 32'hff00_0014, r);
			chk(r, j < 5 ? mr[j] : 0);
		end
		chk({o_card_timing_select, o_card_space_attribute}, mr[4][3:0]);
		chk(o_page_entry_high, mr[0]);
		chk(o_page_entry_low, mr[1]);
		chk(o_page_entry_assist, mr[4]);
		$display("storage done");
		for (j = 0; j < 2; j++) begin
			wctl(32'(j * 5));
			sd = lfsr(sd);
			d = {~sd, sd};
			ev(0, d);
			mr[0] = {d[31:10], mr[0][9:0]};
			mr[3] = d;
			chk(o_page_entry_high, mr[0]);
			chk(o_page_entry_low, mr[1]);
			cpu.rd(off[0], r);
			chk(r, mr[0]);
			cpu.rd(off[3], r);
			chk(r, mr[3]);
		end
		$display("fault done");
		for (k = 0; k < 16; k++) begin
			sd = lfsr(sd);
			ev(1, 32'(sd));
			case (sd[1:0])
				0: lru = lru & 7;
				1: lru = (lru | 32) & 57;
				2: lru = (lru | 20) & 62;
				3: lru = lru | 11;
			endcase
			chk(o_instruction_translation_buffer_victim, (lru & 56) == 56 ? 0 : (lru & 38) == 6 ? 1 :
				(lru & 21) == 1 ? 2 : 3);
		end
		wctl(32'(lru << 26 | 5));
		$display("lru done");
		@(posedge i_clk) i_arst_n <= 0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1;
		repeat (3) @(posedge i_clk);
		cpu.rd(mcr_pkg::MCR_OFF_CTL, r);
		chk(r, 0);
		lru = 0;
		chk(o_instruction_translation_buffer_victim, 3);
		for (j = 0; j < 2; j++) begin
			wctl(32'(lru << 26 | 3 << 18 | (j ? 62 : 0) << 10 | 5));
			for (k = 0; k < 12; k++) begin
				ev(k % 4 == 3 ? 3 : 2, 0);
				if (k % 4 != 3)
					replace_counter = (replace_counter + 1) % 64 == replace_boundary ? 0 : (replace_counter + 1) % 64;
				chk(o_replace_index, replace_counter);
			end
		end
		$display("counter done");
		for (j = 0; j < 8; j++) begin
			wctl(32'(lru << 26 | j[2] * 32'h300 | 5)); // mode change with invalidate
			@(posedge i_clk) {i_sq_access, i_user_mode} <= j[1:0];
			#1 chk(o_sq_addr_error, sqp & j[1] & j[0]);
			chk(o_single_space_mode, sv);
			chk(o_store_queue_protect, sqp);
		end
		$display("queue done");
		report_and_stop;
	end
endmodule // tb_mcr_top
